// [core/bridge_cfg_consts.vh]
// constants for the bridge configuration header register bank
// assumes inclusion by bare name from core/ design files
`ifndef BRIDGE_CFG_CONSTS_VH
`define BRIDGE_CFG_CONSTS_VH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_CLASS_CODE 8'h08
`define ADDR_HDR_DWORD 8'h0c
`define ADDR_BUS_DWORD 8'h18
`define ADDR_IO_DWORD 8'h1c
`define ADDR_WIDTH 8

// ****************************************
// fixed field values
// ****************************************
`define REVISION_ID 8'h00
`define PROG_IF 8'h00
`define SUBCLASS_P2P 8'h04
`define BASECLASS_BRIDGE 8'h06
`define PRI_LAT_VALUE 8'h00
`define HDR_LAYOUT_VALUE 7'h01
`define MULTI_FUNC_VALUE 1'h0
`define SELF_TEST_VALUE 8'h00
`define IO_ADDR32_CODE 2'h1
`define IO_RSVD_VALUE 2'h0
`define CLS_RSVD_LO 2'h0
`define CLS_RSVD_HI 2'h0

// ****************************************
// reset values
// ****************************************
`define CLS_RESET 4'h0
`define BUS_RESET 8'h00
`define SEC_LAT_RESET 8'h40
`define IO_FIELD_RESET 4'h0

// ****************************************
// io window low and upper bits, status half
// ****************************************
`define IO_BASE_LOW 12'h000
`define IO_LIMIT_LOW 12'hfff
`define IO_UPPER_ZERO 16'h0000
`define STATUS_HALF_ZERO 16'h0000

// ****************************************
// field positions
// ****************************************
`define LANE0_BITS 7:0
`define LANE1_BITS 15:8
`define LANE2_BITS 23:16
`define LANE3_BITS 31:24
`define CLS_FIELD_BITS 5:2
`define IO_BASE_BITS 7:4
`define IO_LIMIT_BITS 15:12

// ****************************************
// cache line selections and sizes in doublewords
// ****************************************
`define CLS_SEL_4 4'h1
`define CLS_SEL_8 4'h2
`define CLS_SEL_16 4'h4
`define CLS_SEL_32 4'h8
`define CLS_DW_4 6'h04
`define CLS_DW_8 6'h08
`define CLS_DW_16 6'h10
`define CLS_DW_32 6'h20
`define CLS_DW_NONE 6'h00

// ****************************************
// axi responses
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [core/bridge_config_header_regs.v]
// bridge type-1 header registers at 08h, 0ch, 18h, 1ch behind an axi4-lite slave
// assumes one synchronous clock; forwarding logic elsewhere reads the decoded windows
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "bridge_cfg_consts.vh"

module bridge_config_header_regs (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi write address
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi read address
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // configuration outputs to forwarding logic
  output reg [7:0] upstream_bus_number,
  output reg [7:0] downstream_bus_number,
  output reg [7:0] highest_bus_number,
  output reg [7:0] downstream_latency_timer,
  output reg [5:0] cache_line_dwords,
  output reg [31:0] io_window_base_addr,
  output reg [31:0] io_window_limit_addr
);

  // ****************************************
  // functions
  // ****************************************
  // byte-lane merge of a write into a stored byte
  function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input strobe;
    begin
      merge_byte = strobe ? new_val : old_val;
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `ADDR_CLASS_CODE) || (addr == `ADDR_HDR_DWORD) ||
                  (addr == `ADDR_BUS_DWORD) || (addr == `ADDR_IO_DWORD);
    end
  endfunction

  // unmapped offsets answer with a slave error and change nothing
  function [1:0] resp_code;
    input [7:0] addr;
    begin
      if (is_mapped(addr))
      begin
        resp_code = `RESP_OKAY;
      end
      else
      begin
        resp_code = `RESP_SLVERR;
      end
    end
  endfunction

  // a pattern that is not one-hot has no defined size and decodes to zero
  function [5:0] line_dwords;
    input [3:0] sel;
    begin
      case (sel)
        `CLS_SEL_4: line_dwords = `CLS_DW_4;
        `CLS_SEL_8: line_dwords = `CLS_DW_8;
        `CLS_SEL_16: line_dwords = `CLS_DW_16;
        `CLS_SEL_32: line_dwords = `CLS_DW_32;
        default: line_dwords = `CLS_DW_NONE;
      endcase
    end
  endfunction

  // ****************************************
  // storage
  // ****************************************
  reg [3:0] cls_bits;
  reg [3:0] io_base_field;
  reg [3:0] io_limit_field;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  // ****************************************
  // read-back images
  // ****************************************
  wire [7:0] cls_byte;
  wire [31:0] class_dword;
  wire [31:0] hdr_dword;
  wire [31:0] bus_dword;
  wire [31:0] io_dword;
  wire [7:0] io_base_byte;
  wire [7:0] io_limit_byte;

  assign cls_byte = {`CLS_RSVD_HI, cls_bits, `CLS_RSVD_LO};
  assign class_dword = {`BASECLASS_BRIDGE, `SUBCLASS_P2P, `PROG_IF, `REVISION_ID};
  assign hdr_dword = {`SELF_TEST_VALUE, `MULTI_FUNC_VALUE, `HDR_LAYOUT_VALUE,
                      `PRI_LAT_VALUE, cls_byte};
  assign bus_dword = {downstream_latency_timer, highest_bus_number,
                      downstream_bus_number, upstream_bus_number};
  assign io_base_byte = {io_base_field, `IO_RSVD_VALUE, `IO_ADDR32_CODE};
  assign io_limit_byte = {io_limit_field, `IO_RSVD_VALUE, `IO_ADDR32_CODE};
  // upper half belongs to secondary status, kept outside this bank
  assign io_dword = {`STATUS_HALF_ZERO, io_limit_byte, io_base_byte};

  // ****************************************
  // write channel
  // ****************************************
  wire do_write;
  wire aw_take;
  wire w_take;
  wire [7:0] next_cls_byte;
  // a pending response blocks the next write so bresp is never overwritten
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign next_cls_byte = merge_byte(cls_byte, w_data[`LANE0_BITS], w_strb[0]);

  // address slot; ready pulses one cycle while the slot is empty
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (aw_take)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
      end
    end
  end

  // data slot; either slot may fill first, the write waits for both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (do_write)
      begin
        w_held <= 1'b0;
      end
    end
  end

  // response stands until the master takes it
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= resp_code(aw_addr);
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only writable fields are stored; fixed bits are rebuilt on read
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cls_bits <= `CLS_RESET;
      upstream_bus_number <= `BUS_RESET;
      downstream_bus_number <= `BUS_RESET;
      highest_bus_number <= `BUS_RESET;
      downstream_latency_timer <= `SEC_LAT_RESET;
      io_base_field <= `IO_FIELD_RESET;
      io_limit_field <= `IO_FIELD_RESET;
    end
    else if (do_write)
    begin
      case (aw_addr)
        `ADDR_HDR_DWORD:
        begin
          cls_bits <= next_cls_byte[`CLS_FIELD_BITS];
        end
        `ADDR_BUS_DWORD:
        begin
          upstream_bus_number <= merge_byte(upstream_bus_number, w_data[`LANE0_BITS], w_strb[0]);
          downstream_bus_number <= merge_byte(downstream_bus_number, w_data[`LANE1_BITS], w_strb[1]);
          highest_bus_number <= merge_byte(highest_bus_number, w_data[`LANE2_BITS], w_strb[2]);
          downstream_latency_timer <= merge_byte(downstream_latency_timer, w_data[`LANE3_BITS], w_strb[3]);
        end
        `ADDR_IO_DWORD:
        begin
          if (w_strb[0])
          begin
            io_base_field <= w_data[`IO_BASE_BITS];
          end
          if (w_strb[1])
          begin
            io_limit_field <= w_data[`IO_LIMIT_BITS];
          end
        end
        default:
        begin
          cls_bits <= cls_bits;
        end
      endcase
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  // fixed fields come from constants, so only writable fields need storage
  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h00000000;
    case (s_axi_araddr)
      `ADDR_CLASS_CODE: next_rdata = class_dword;
      `ADDR_HDR_DWORD: next_rdata = hdr_dword;
      `ADDR_BUS_DWORD: next_rdata = bus_dword;
      `ADDR_IO_DWORD: next_rdata = io_dword;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      // one read in flight; arready only while no data is pending
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= resp_code(s_axi_araddr);
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // decoded outputs
  // ****************************************
  // registered so forwarding logic sees a clean edge, one cycle behind the fields
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cache_line_dwords <= `CLS_DW_NONE;
    end
    else
    begin
      cache_line_dwords <= line_dwords(cls_bits);
    end
  end

  // upper 16 io address bits are not held here, so they read as zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      io_window_base_addr <= {`IO_UPPER_ZERO, `IO_FIELD_RESET, `IO_BASE_LOW};
      io_window_limit_addr <= {`IO_UPPER_ZERO, `IO_FIELD_RESET, `IO_LIMIT_LOW};
    end
    else
    begin
      io_window_base_addr <= {`IO_UPPER_ZERO, io_base_field, `IO_BASE_LOW};
      io_window_limit_addr <= {`IO_UPPER_ZERO, io_limit_field, `IO_LIMIT_LOW};
    end
  end

endmodule

// [bench/bridge_regs_checker.sv]
// checker for the bridge header register bank
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ps
module bridge_regs_checker (
  // clock, reset, bus
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  // decoded outputs
  input wire [7:0] upstream_bus_number,
  input wire [7:0] downstream_bus_number,
  input wire [7:0] highest_bus_number,
  input wire [7:0] downstream_latency_timer,
  input wire [5:0] cache_line_dwords,
  input wire [31:0] io_window_base_addr,
  input wire [31:0] io_window_limit_addr
);
  // ****
  // read address in flight
  // ****
  reg [7:0] rd_addr;
  always @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_vals: assert property ($rose(aresetn) |->
    {downstream_latency_timer, highest_bus_number, downstream_bus_number, upstream_bus_number} == 32'h4000_0000)
    else $error("bus dword reset value wrong");
  // bus fields change on the edge that raises bvalid; the cycle after bvalid is allowed too
  chk_bus_write: assert property ($changed({downstream_latency_timer, upstream_bus_number}) ||
    $changed({downstream_bus_number, highest_bus_number}) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("bus field changed without a write");
  chk_cls_decode: assert property (s_axi_rvalid && rd_addr == 8'h0c && $onehot(s_axi_rdata[5:2]) &&
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> cache_line_dwords == {s_axi_rdata[5:2], 2'h0})
    else $error("cache line size decode wrong");
  chk_io_base_low: assert property (s_axi_rvalid && rd_addr == 8'h1c &&
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> io_window_base_addr == {16'h0000, s_axi_rdata[7:4], 12'h000})
    else $error("io base window wrong");
  chk_io_limit_low: assert property (s_axi_rvalid && rd_addr == 8'h1c &&
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> io_window_limit_addr == {16'h0000, s_axi_rdata[15:12], 12'hfff})
    else $error("io limit window wrong");
  chk_rd_header: assert property (s_axi_rvalid && rd_addr == 8'h0c |->
    s_axi_rdata[31:8] == 24'h000100 && s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[7:6] == 2'h0)
    else $error("header dword fixed bits wrong");
  chk_rd_io: assert property (s_axi_rvalid && rd_addr == 8'h1c |->
    s_axi_rdata[3:0] == 4'h1 && s_axi_rdata[11:8] == 4'h1)
    else $error("io dword fixed bits wrong");
  chk_rd_class: assert property (s_axi_rvalid && rd_addr == 8'h08 |-> s_axi_rdata[31:16] == 16'h0604)
    else $error("class code wrong");
endmodule
bind bridge_config_header_regs bridge_regs_checker bridge_regs_checker_inst (.*);

// [bench/bridge_config_header_regs_bench.sv]
// self-checking bench for the bridge header register bank
// assumes the design and checker compiled alongside
`timescale 1ns/1ps
module bridge_config_header_regs_bench;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, iob, iol;
  wire [7:0] ub, db, hb, lt;
  wire [5:0] cl;
  integer errors = 0;
  integer n_checks = 0;
  reg [31:0] d;
  reg [1:0] r;
  integer i;
  always #2.5 aclk = ~aclk;
  bridge_config_header_regs bridge_config_header_regs_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .upstream_bus_number(ub), .downstream_bus_number(db), .highest_bus_number(hb),
    .downstream_latency_timer(lt), .cache_line_dwords(cl), .io_window_base_addr(iob),
    .io_window_limit_addr(iol));
  // ****
  // bus tasks
  // ****
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // ready is looked at on the falling edge, so it is the value the next rising edge samples
  task wr(input [7:0] a, input [31:0] v, input [3:0] s);
    reg pa, pw;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw)
      begin
        @(negedge aclk);
        if (awready === 1'b1) pa = 1'b0;
        if (wready === 1'b1) pw = 1'b0;
        @(posedge aclk);
        awvalid <= pa;
        wvalid <= pw;
      end
      @(negedge aclk);
      while (bvalid !== 1'b1) @(negedge aclk);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge aclk);
      while (arready !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      arvalid <= 1'b0;
      @(negedge aclk);
      while (rvalid !== 1'b1) @(negedge aclk);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
    end
  endtask
  // ****
  // tests
  // ****
  task t_reset;
    begin
      rd(8'h0c);
      chk(d, 32'h0001_0000, "hdr");
      rd(8'h18);
      chk(d, 32'h4000_0000, "bus");
      chk(r, 32'h0, "rd resp");
      chk({lt, hb, db, ub}, 32'h4000_0000, "bus ports");
      chk(cl, 32'h0, "cls dwords");
      chk(iob, 32'h0000_0000, "io base");
      chk(iol, 32'h0000_0fff, "io limit");
      rd(8'h1c);
      chk(d, 32'h0000_0101, "io");
      rd(8'h08);
      chk(d[31:16], 32'h0604, "class");
      $display("reset test done");
    end
  endtask
  task t_cls;
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        wr(8'h0c, 32'hffff_ffc3 | (32'h4 << i), 4'hf);
        rd(8'h0c);
        chk(d, 32'h0001_0000 | (32'h4 << i), "cls");
        chk(cl, 32'd4 << i, "cls dwords");
      end
      wr(8'h0c, 32'h0000_000c, 4'h1);
      rd(8'h0c);
      chk(d, 32'h0001_000c, "cls two bits");
      chk(cl, 32'h0, "cls dwords");
      $display("cls test done");
    end
  endtask
  task t_bus;
    begin
      wr(8'h18, 32'h1234_5678, 4'hf);
      chk(r, 32'h0, "wr resp");
      rd(8'h18);
      chk(d, 32'h1234_5678, "bus");
      chk({lt, hb, db, ub}, 32'h1234_5678, "bus ports");
      wr(8'h18, 32'hffff_ffff, 4'h2);
      rd(8'h18);
      chk(d, 32'h1234_ff78, "bus lane");
      $display("bus test done");
    end
  endtask
  task t_io;
    begin
      wr(8'h1c, 32'hffff_ffff, 4'hf);
      rd(8'h1c);
      chk(d, 32'h0000_f1f1, "io");
      wr(8'h1c, 32'h0000_5030, 4'h3);
      rd(8'h1c);
      chk(d, 32'h0000_5131, "io");
      chk(iob, 32'h0000_3000, "io base");
      chk(iol, 32'h0000_5fff, "io limit");
      $display("io test done");
    end
  endtask
  // unmapped access, then a reset in mid run
  task t_bad;
    begin
      wr(8'h10, 32'hffff_ffff, 4'hf);
      chk(r, 32'h2, "wr resp");
      rd(8'h10);
      chk(r, 32'h2, "rd resp");
      chk(d, 32'h0, "rd data");
      rd(8'h18);
      chk(d, 32'h1234_ff78, "bus kept");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h18);
      chk(d, 32'h4000_0000, "bus");
      chk({lt, hb, db, ub}, 32'h4000_0000, "bus ports");
      $display("bad access test done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_cls;
    t_bus;
    t_io;
    t_bad;
    final_report;
  end
  // about 30 transfers of under 10 cycles each
  initial
  begin
    repeat (3000) @(posedge aclk);
    errors = errors + 1;
    final_report;
  end
endmodule
